// file: pkg/jcl_pkg.sv
// constants and carrier types for the test-port configuration loader (host end)
// assumes a single device or a chain whose other members take the bypass opcode
// Contract
// - hold tms high five clocks, then one low
// - from idle, tms high two, low two
// - shift load opcode lsb first, six bits
// - last opcode bit zero with tms high
// - after instruction, high two, low two to shift-dr
// - bitstream goes msb first into configuration register
// - all but last bit with tms low
// - pass update-dr then go back toward shift-ir
// - startup opcode lsb first, exit, update-ir
// - at least sixteen idle clocks after startup opcode
// - tms high three clocks to reset
// - reconfigure after program pulse, then reload
// - chain: target gets load, others bypass
// - startup opcode to all, sixteen idle clocks
// - host spends enough idle clocks for other sources
// - clock startup and shutdown from test clock
// - instruction register six bits wide
package jcl_pkg;
   localparam int unsigned JCL_IR_W = 6;
   localparam logic [5:0] JCL_OP_CFG_LOAD = 6'h05;
   localparam logic [5:0] JCL_OP_STARTUP_CLOCK_INSTR = 6'h0c;
   localparam logic [5:0] JCL_OP_INSYS_CONFIG_BEGIN_INSTR = 6'h10;
   localparam logic [5:0] JCL_OP_INSYS_CONFIG_END_INSTR = 6'h16;
   localparam logic [5:0] JCL_OP_BYPASS = 6'h3f;
   localparam int unsigned JCL_RESET_CLKS = 5;
   localparam int unsigned JCL_IDLE_MIN_CLKS = 16;
   localparam int unsigned JCL_EXIT_CLKS = 3;
   localparam int unsigned JCL_PROG_CLKS = 4;
   // tck half period in sys_clk cycles
   localparam int unsigned JCL_TCK_HALF = 2;
   localparam int unsigned JCL_CNT_W = 32;
   localparam int unsigned JCL_DEV_W = 4;
   localparam int unsigned JCL_DATA_W = 8;

   typedef enum logic [0:0] {JCL_PH_LOW, JCL_PH_HIGH} jcl_phase_e;

   // one tck slot: levels of tms and tdi during it
   typedef struct packed {
      logic tms;
      logic tdi;
   } jcl_slot_s;

   // test port pins driven by the host
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic program_n;
   } jcl_pins_s;

   // start request from user logic
   typedef struct packed {
      logic reprogram;
      logic [JCL_DEV_W-1:0] chain_len;
      logic [JCL_DEV_W-1:0] target;
      logic last_device;
      logic [JCL_CNT_W-1:0] nbits;
      logic [JCL_CNT_W-1:0] idle_clks;
   } jcl_req_s;
endpackage

// file: rtl/jcl_fifo.sv
// small synchronous fifo for bitstream bytes
// assumes one clock, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module jcl_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic rdy;
   } jcl_fifo_s;
   jcl_fifo_s st_q;
   jcl_fifo_s st_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // handshake qualifiers
   assign in_ready = st_q.rdy; // registered so the fill side sees a flop
   assign out_valid = (st_q.cnt != '0);
   assign out_data = mem[st_q.rp];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;

   // pointer and count update
   always_comb
   begin
      st_d = st_q;
      if (push)
      begin
         st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
      end
      if (pop)
      begin
         st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
      end
      if (push && !pop)
      begin
         st_d.cnt = st_q.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         st_d.cnt = st_q.cnt - 1'b1;
      end
      st_d.rdy = (st_d.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         st_q <= '0;
         st_q.rdy <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // storage write
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[st_q.wp] <= in_data;
      end
   end
endmodule
`default_nettype wire

// file: rtl/jcl_host.sv
// test-port host that loads a bitstream into one device of a scan chain
// assumes tdo comes from outside and tck is made here by dividing sys_clk
`timescale 1ns/1ps
`default_nettype none
module jcl_host
   import jcl_pkg::*;
#(
   parameter int unsigned DATA_W = JCL_DATA_W,
   parameter int unsigned FIFO_DEPTH = 8,
   parameter int unsigned IDLE_MIN = JCL_IDLE_MIN_CLKS
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   // request from user logic
   input wire logic start,
   input wire jcl_req_s req,
   output logic busy,
   output logic done,
   // bitstream bytes, msb of each byte first
   input wire logic data_valid,
   output logic data_ready,
   input wire logic [DATA_W-1:0] data,
   // test port pins
   output jcl_pins_s pins,
   input wire logic tdo,
   output logic tdo_seen
);
   typedef enum logic [3:0] {
      S_IDLE, S_PROG, S_RESET, S_TO_IR, S_IR, S_TO_DR, S_DR, S_POST_DR, S_IDLE_RUN, S_EXIT, S_DONE
   } jcl_state_e;

   typedef struct packed {
      jcl_state_e st;
      jcl_phase_e ph;
      logic [7:0] div;
      logic [JCL_CNT_W-1:0] cnt;
      logic [JCL_DEV_W-1:0] dev;
      logic startup;
      logic [DATA_W-1:0] sh;
      logic [$clog2(DATA_W+1)-1:0] nb;
      jcl_req_s rq;
      jcl_pins_s pins;
      logic busy;
      logic done;
      logic tdo_seen;
      logic [1:0] tdo_sync;
   } jcl_host_s;

   jcl_host_s q;
   jcl_host_s d;
   logic fifo_valid;
   logic fifo_pop;
   logic [DATA_W-1:0] fifo_data;
   logic fall;
   logic [JCL_CNT_W-1:0] ir_len;

   // opcode bit of device dev at chain position pos; other devices get bypass, all devices get startup when su
   function automatic logic ir_bit(input logic [JCL_DEV_W-1:0] tgt, input logic [JCL_CNT_W-1:0] pos,
                                   input logic su, input logic [JCL_DEV_W-1:0] len);
      logic [JCL_DEV_W-1:0] dv;
      logic [2:0] b;
      logic [5:0] op;
      dv = JCL_DEV_W'(pos / JCL_IR_W);
      b = 3'(pos % JCL_IR_W);
      if (su)
      begin
         op = JCL_OP_STARTUP_CLOCK_INSTR;
      end
      else if (dv == tgt)
      begin
         op = JCL_OP_CFG_LOAD;
      end
      else
      begin
         op = JCL_OP_BYPASS;
      end
      ir_bit = (dv < len) ? op[b] : 1'b1;
   endfunction

   // bitstream buffer between source and shifter
   jcl_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .in_valid(data_valid),
      .in_ready(data_ready),
      .in_data(data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // one tck period is a low half then a high half; tms and tdi change only at the falling edge
   assign fall = (q.ph == JCL_PH_HIGH) && (q.div == 8'(JCL_TCK_HALF - 1));
   assign ir_len = JCL_CNT_W'(q.rq.chain_len) * JCL_CNT_W'(JCL_IR_W);
   assign fifo_pop = fall && (q.st == S_DR) && (q.nb == '0) && (q.cnt != '0);
   assign busy = q.busy;
   assign done = q.done;
   assign pins = q.pins;
   assign tdo_seen = q.tdo_seen;

   // sequencer
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      d.tdo_sync = {q.tdo_sync[0], tdo};
      if (q.st != S_IDLE && q.st != S_PROG)
      begin
         if (q.div == 8'(JCL_TCK_HALF - 1))
         begin
            d.div = '0;
            d.ph = (q.ph == JCL_PH_LOW) ? JCL_PH_HIGH : JCL_PH_LOW;
            d.pins.tck = (q.ph == JCL_PH_LOW);
         end
         else
         begin
            d.div = q.div + 1'b1;
         end
         // tdo moves at tck fall and needs the low half to cross the synchroniser: take it one clock after the rise
         if (q.ph == JCL_PH_HIGH && q.div == '0)
         begin
            d.tdo_seen = q.tdo_sync[1];
         end
      end
      case (q.st)
         S_IDLE:
         begin
            d.pins.tck = 1'b0;
            if (start)
            begin
               d.rq = req;
               d.busy = 1'b1;
               d.dev = req.target;
               d.startup = 1'b0;
               d.div = '0;
               d.ph = JCL_PH_LOW;
               d.pins.tms = 1'b1;
               d.cnt = JCL_CNT_W'(JCL_RESET_CLKS);
               d.st = S_RESET;
               if (req.reprogram)
               begin
                  d.pins.program_n = 1'b0;
                  d.cnt = JCL_CNT_W'(JCL_PROG_CLKS);
                  d.st = S_PROG;
               end
            end
         end
         S_PROG:
         begin
            if (q.cnt == JCL_CNT_W'(1))
            begin
               d.pins.program_n = 1'b1;
               d.cnt = JCL_CNT_W'(JCL_RESET_CLKS);
               d.st = S_RESET;
            end
            else
            begin
               d.cnt = q.cnt - 1'b1;
            end
         end
         default:
         begin
            if (fall)
            begin
               d.cnt = q.cnt - 1'b1;
               case (q.st)
                  S_RESET:
                  begin
                     if (q.cnt == JCL_CNT_W'(1))
                     begin
                        d.pins.tms = 1'b0;
                        d.cnt = JCL_CNT_W'(5);
                        d.st = S_TO_IR;
                     end
                  end
                  S_TO_IR:
                  begin
                     // one idle clock, two high, two low
                     d.pins.tms = (q.cnt == JCL_CNT_W'(5) || q.cnt == JCL_CNT_W'(4));
                     if (q.cnt == JCL_CNT_W'(1))
                     begin
                        d.cnt = ir_len;
                        d.pins.tdi = ir_bit(q.dev, '0, q.startup, q.rq.chain_len);
                        d.pins.tms = (ir_len == JCL_CNT_W'(1));
                        d.st = S_IR;
                     end
                  end
                  S_IR:
                  begin
                     if (q.cnt == JCL_CNT_W'(1))
                     begin
                        d.pins.tms = 1'b1;
                        d.pins.tdi = 1'b0;
                        d.cnt = q.startup ? JCL_CNT_W'(1) : JCL_CNT_W'(3);
                        d.st = S_TO_DR;
                     end
                     else
                     begin
                        // opcode lsb first, final zero with tms high
                        d.pins.tdi = ir_bit(q.dev, ir_len - q.cnt + 1'b1, q.startup, q.rq.chain_len);
                        d.pins.tms = (q.cnt == JCL_CNT_W'(2));
                     end
                  end
                  S_TO_DR:
                  begin
                     if (q.startup)
                     begin
                        // update-ir then idle
                        d.pins.tms = 1'b0;
                        if (q.cnt == JCL_CNT_W'(1))
                        begin
                           // one extra slot: the last idle slot already raises tms toward reset
                           d.cnt = ((q.rq.idle_clks > JCL_CNT_W'(IDLE_MIN)) ? q.rq.idle_clks : JCL_CNT_W'(IDLE_MIN))
                                   + 1'b1;
                           d.st = S_IDLE_RUN;
                        end
                        else
                        begin
                           d.pins.tms = 1'b1;
                        end
                     end
                     else
                     begin
                        // first high slot was set on leaving shift-ir, one more high, then two low
                        d.pins.tms = (q.cnt == JCL_CNT_W'(3));
                        if (q.cnt == JCL_CNT_W'(1))
                        begin
                           // each bypassed device between tdi and the target delays the stream one bit
                           d.cnt = q.rq.nbits + JCL_CNT_W'(JCL_DEV_W'(q.rq.chain_len - q.dev - 1'b1));
                           d.nb = '0;
                           d.st = S_DR;
                        end
                     end
                  end
                  S_DR:
                  begin
                     if (q.cnt == '0)
                     begin
                        d.cnt = q.cnt;
                     end
                     else if (q.nb == '0)
                     begin
                        if (fifo_valid)
                        begin
                           d.pins.tdi = fifo_data[DATA_W-1];
                           d.sh = {fifo_data[DATA_W-2:0], 1'b0};
                           d.nb = ($bits(d.nb))'(DATA_W - 1);
                           d.pins.tms = (q.cnt == JCL_CNT_W'(1));
                        end
                        else
                        begin
                           // starved: wait, tck keeps running in pause state is avoided by holding count
                           d.cnt = q.cnt;
                        end
                     end
                     else
                     begin
                        d.pins.tdi = q.sh[DATA_W-1];
                        d.sh = {q.sh[DATA_W-2:0], 1'b0};
                        d.nb = q.nb - 1'b1;
                        d.pins.tms = (q.cnt == JCL_CNT_W'(1));
                     end
                     if (q.cnt == '0 && q.pins.tms)
                     begin
                        d.pins.tms = 1'b1;
                        d.cnt = JCL_CNT_W'(3);
                        d.st = S_POST_DR;
                     end
                  end
                  S_POST_DR:
                  begin
                     // update-dr, then tms high through idle-less path to select-ir
                     d.pins.tms = (q.cnt != JCL_CNT_W'(1));
                     if (q.cnt == JCL_CNT_W'(1))
                     begin
                        d.startup = q.rq.last_device;
                        // already in capture-ir: one low slot left before shift-ir
                        d.cnt = JCL_CNT_W'(2);
                        d.st = q.rq.last_device ? S_TO_IR : S_DONE;
                     end
                  end
                  S_IDLE_RUN:
                  begin
                     d.pins.tms = 1'b0;
                     if (q.cnt == JCL_CNT_W'(1))
                     begin
                        d.pins.tms = 1'b1;
                        d.cnt = JCL_CNT_W'(JCL_EXIT_CLKS);
                        d.st = S_EXIT;
                     end
                  end
                  S_EXIT:
                  begin
                     if (q.cnt == JCL_CNT_W'(1))
                     begin
                        d.st = S_DONE;
                     end
                  end
                  default:
                  begin
                     d.busy = 1'b0;
                     d.done = 1'b1;
                     d.pins.tms = 1'b1;
                     d.st = S_IDLE;
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         q <= '0;
         q.st <= S_IDLE;
         q.pins.tms <= 1'b1;
         q.pins.program_n <= 1'b1;
      end
      else if (ce)
      begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// file: tb/jcl_host_props.sv
// port checker for the test-port host
// assumes one sys_clk domain with async reset, bound into jcl_host
`timescale 1ns/1ps
`default_nettype none
module jcl_host_props
   import jcl_pkg::*;
(
   // clock and control
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic start,
   input wire jcl_req_s req,
   input wire logic busy,
   input wire logic done,
   // test port pins
   input wire jcl_pins_s pins
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset || !ce);

   // tck high half and the program pulse shape
   sequence s_tck_high;
      pins.tck [*2] ##1 !pins.tck;
   endsequence
   sequence s_prog_low;
      !pins.program_n [*4] ##1 pins.program_n;
   endsequence

   chk_tck_high: assert property ($rose(pins.tck) |-> s_tck_high)
      else $error("tck high phase wrong");
   chk_tck_low: assert property ($fell(pins.tck) |=> !pins.tck)
      else $error("tck low phase short");
   chk_pins_stable: assert property (busy && ($changed(pins.tms) || $changed(pins.tdi)) |-> $fell(pins.tck))
      else $error("tms or tdi moved off tck fall");
   chk_busy_start: assert property (start && !busy |=> busy)
      else $error("start not taken");
   chk_done_pulse: assert property (done |=> !done)
      else $error("done longer than one clock");
   chk_busy_end: assert property ($fell(busy) |-> done || $past(done))
      else $error("busy dropped without done");
   chk_prog_pulse: assert property ($fell(pins.program_n) |-> s_prog_low)
      else $error("program pulse not four clocks");
   chk_prog_cause: assert property (start && !busy && req.reprogram |-> ##[1:8] !pins.program_n)
      else $error("program pulse missing");
   chk_prog_idle: assert property (!busy && !$past(busy) |-> pins.program_n)
      else $error("program pin low while idle");
   cover_done: cover property (done);
endmodule

bind jcl_host jcl_host_props i_jcl_host_props (
   .sys_clk(sys_clk), .reset(reset), .ce(ce), .start(start),
   .req(req), .busy(busy), .done(done), .pins(pins)
);
`default_nettype wire

// file: tb/jcl_dev_model.sv
// behavioural device on the test port: tap controller, six-bit ir, stream register
// assumes tck, tms, tdi come from the host or the previous device in the chain
`timescale 1ns/1ps
`default_nettype none
module jcl_dev_model
   import jcl_pkg::*;
(
   // test port
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic program_n,
   output logic tdo
);
   // tap next state for tms low and tms high, codes 0..15
   int nx0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
   int nx1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
   int st = 7; // powers up away from reset, so the host must walk it there
   int su_cnt = 0;
   int sd_cnt = 0;
   int prog_cnt = 0;
   logic [JCL_IR_W-1:0] ir = JCL_OP_BYPASS;
   logic [JCL_IR_W-1:0] ir_sh = '0;
   logic [JCL_IR_W-1:0] ir_last = '0;
   logic [15:0] cfg_sr = '0;
   logic byp = 1'b0;
   logic cfg_q[$];

   // tap actions on tck rise; startup and shutdown always clocked by tck
   always @(posedge tck)
   begin
      case (st)
         0: ir = JCL_OP_BYPASS;
         1: if (!tms && (ir == JCL_OP_STARTUP_CLOCK_INSTR || ir == JCL_OP_INSYS_CONFIG_END_INSTR))
               su_cnt++;
            else if (!tms && ir == JCL_OP_INSYS_CONFIG_BEGIN_INSTR)
               sd_cnt++;
         3: begin cfg_q.delete(); byp = 1'b0; end
         4: if (ir == JCL_OP_CFG_LOAD)
            begin
               cfg_q.push_back(tdi);
               cfg_sr = {cfg_sr[14:0], tdi};
            end
            else byp = tdi;
         10: ir_sh = 6'h01;
         11: ir_sh = {tdi, ir_sh[5:1]};
         15: begin ir = ir_sh; ir_last = ir_sh; end
         default: ;
      endcase
      st = tms ? nx1[st] : nx0[st];
   end

   // tdo moves on tck fall and toggles outside a shift so no stale level lingers
   initial tdo = 1'b0;
   always @(negedge tck)
      if (st == 11) tdo <= ir_sh[0];
      else if (st == 4) tdo <= (ir == JCL_OP_CFG_LOAD) ? cfg_sr[15] : byp;
      else tdo <= ~tdo;

   // a program pulse wipes the loaded stream
   always @(negedge program_n)
   begin
      prog_cnt++;
      cfg_q.delete();
   end
endmodule
`default_nettype wire

// file: tb/jcl_host_test.sv
// self-checking bench for the test-port host with a two-device chain
// assumes jcl_host, jcl_dev_model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module jcl_host_test import jcl_pkg::*; ;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic start = 1'b0;
   jcl_req_s req = '0;
   logic busy;
   logic done;
   logic data_valid = 1'b0;
   logic data_ready;
   logic [7:0] data = 8'h00;
   logic tdo_seen;
   jcl_pins_s pins;
   wire logic mid_tdo;
   wire logic tdo;
   int err_count = 0;
   int checked = 0;
   logic [7:0] img[$];
   logic exp_q[$];

   jcl_host i_jcl_host (.sys_clk(sys_clk), .reset(reset), .ce(ce), .start(start), .req(req), .busy(busy),
      .done(done), .data_valid(data_valid), .data_ready(data_ready), .data(data), .pins(pins), .tdo(tdo),
      .tdo_seen(tdo_seen));
   // chain: position 1 next to tdi, position 0 next to tdo
   jcl_dev_model i_dev1 (.tck(pins.tck), .tms(pins.tms), .tdi(pins.tdi), .program_n(pins.program_n),
      .tdo(mid_tdo));
   jcl_dev_model i_dev0 (.tck(pins.tck), .tms(pins.tms), .tdi(mid_tdo), .program_n(pins.program_n), .tdo(tdo));

   // 10 MHz system clock
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // random image and the bit order the target must see
   task automatic make_image(input int nbits);
      img.delete();
      exp_q.delete();
      // one byte beyond the last whole one covers the bypass pad bit
      for (int i = 0; i < nbits / 8 + 1; i++) img.push_back(8'($urandom_range(255)));
      for (int i = 0; i < nbits; i++) exp_q.push_back(img[i / 8][7 - i % 8]);
   endtask

   // bytes into the fifo with random gaps, called at a falling edge
   task automatic feed(input int first, input int last);
      int g = 0;
      for (int i = first; i < last; i++)
      begin
         if (g > 0)
         begin
            data_valid = 1'b0;
            repeat (g) @(negedge sys_clk);
         end
         data_valid = 1'b1;
         data = img[i];
         while (data_ready !== 1'b1) @(negedge sys_clk);
         @(negedge sys_clk);
         g = $urandom_range(2);
      end
      data_valid = 1'b0;
   endtask

   task automatic run(input jcl_req_s r);
      int n = 0;
      req = r;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      check(busy, 1'b1);
      while (done !== 1'b1 && n < 20000)
      begin
         @(negedge sys_clk);
         n++;
      end
      check(done, 1'b1);
   endtask

   // the stream seen by a device ends with the image, after the bypass pads
   task automatic check_stream(input logic got[$], input int exp_len);
      check(got.size(), exp_len);
      for (int i = 0; i < exp_q.size() && exp_len == got.size(); i++)
         check(got[got.size() - exp_q.size() + i], exp_q[i]);
   endtask

   // tdo as the chain shows it at each tck rise must reach tdo_seen one clock later
   always @(posedge pins.tck)
   begin
      logic t;
      t = tdo;
      @(negedge sys_clk);
      @(negedge sys_clk);
      if (busy === 1'b1)
         check(tdo_seen, t);
   end

   // watchdog
   initial
   begin
      #(40000 * 100);
      err_count++;
      finish_test();
   end

   initial
   begin
      jcl_req_s r;
      int nb;
      void'($urandom(18));
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'b0;
      // start with clock enable low is not taken
      ce = 1'b0;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      ce = 1'b1;
      @(negedge sys_clk);
      check(busy, 1'b0);
      // far device of the chain, fifo filled until it refuses first
      nb = 93;
      make_image(nb);
      feed(0, 8);
      check(data_ready, 1'b0);
      r = '0;
      r.chain_len = 4'h2;
      r.target = 4'h1;
      r.nbits = nb;
      r.idle_clks = 16;
      fork
         run(r);
         feed(8, 12);
      join
      check(i_dev1.ir_last, JCL_OP_CFG_LOAD);
      check(i_dev0.ir_last, JCL_OP_BYPASS);
      check_stream(i_dev1.cfg_q, nb);
      check(data_ready, 1'b1);
      // near device, reprogram first, startup for the whole chain, a stray start meanwhile
      nb = 40 + $urandom_range(39);
      make_image(nb);
      r.reprogram = 1'b1;
      r.target = 4'h0;
      r.last_device = 1'b1;
      r.nbits = nb;
      r.idle_clks = 16 + $urandom_range(3);
      fork
         run(r);
         feed(0, img.size());
         begin
            repeat (60) @(negedge sys_clk);
            start = 1'b1;
            @(negedge sys_clk);
            start = 1'b0;
         end
      join
      repeat (8) @(negedge sys_clk);
      check(busy, 1'b0);
      check(i_dev0.prog_cnt, 1);
      check_stream(i_dev0.cfg_q, nb + 1);
      check(i_dev0.ir_last, JCL_OP_STARTUP_CLOCK_INSTR);
      check(i_dev1.ir_last, JCL_OP_STARTUP_CLOCK_INSTR);
      check(i_dev0.su_cnt >= r.idle_clks, 1'b1);
      check(i_dev1.su_cnt >= r.idle_clks, 1'b1);
      check(i_dev0.st, 0);
      finish_test();
   end
endmodule
`default_nettype wire
